//--- shared/aarx_pkg.sv
// register map, field positions and frame constants for the receive filter
package aarx_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [5:0] OFF_SIGNAL_STATUS = 6'h06;
   localparam logic [5:0] OFF_BUF_PROTECT   = 6'h0c;
   localparam logic [5:0] OFF_EXT_ACK       = 6'h17;
   localparam logic [5:0] OFF_SHORT_LO      = 6'h20;
   localparam logic [5:0] OFF_SHORT_HI      = 6'h21;
   localparam logic [5:0] OFF_NETID_LO      = 6'h22;
   localparam logic [5:0] OFF_NETID_HI      = 6'h23;
   localparam logic [5:0] OFF_LONG_FIRST    = 6'h24;
   localparam logic [5:0] OFF_LONG_LAST     = 6'h2b;
   localparam logic [5:0] OFF_SLOTTED       = 6'h2c;
   localparam logic [5:0] OFF_ACK_FILTER    = 6'h2e;

   // ****************************************
   // field positions
   // ****************************************
   localparam int BIT_FCS_VALID   = 7;
   localparam int BIT_BUF_PROTECT = 7;
   localparam int BIT_PROMISC     = 1;
   localparam int BIT_SLOTTED     = 0;
   localparam int BIT_COORD       = 3;
   localparam int BIT_ACK_DISABLE = 4;
   localparam int BIT_ACK_PENDING = 5;
   localparam int POS_VER_POLICY  = 6;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [15:0] RST_SHORT_ADDR = 16'hffff;
   localparam logic [15:0] RST_NETID      = 16'h0000;
   localparam logic [63:0] RST_LONG_ADDR  = 64'h0000_0000_0000_0000;
   localparam logic [7:0]  RST_BUF_CTRL   = 8'h00;
   localparam logic [7:0]  RST_EXT_ACK    = 8'h00;
   localparam logic [7:0]  RST_SLOTTED    = 8'h00;
   localparam logic [7:0]  RST_ACK_FILTER = 8'h40;

   // ****************************************
   // frame constants
   // ****************************************
   localparam logic [15:0] BCAST_ID       = 16'hffff;
   localparam logic [1:0]  AMODE_NONE     = 2'h0;
   localparam logic [1:0]  AMODE_SHORT    = 2'h2;
   localparam logic [1:0]  AMODE_LONG     = 2'h3;
   localparam logic [2:0]  FTYPE_BEACON   = 3'h0;

   typedef enum logic [1:0] {
      AARX_IDLE  = 2'b00,
      AARX_FRAME = 2'b01
   } aarx_state_t;

endpackage

//--- verilog/aarx_filter.sv
// receive frame acceptance, address filter and auto-acknowledge control
`timescale 1ns/10ps
// How it works
// - match frames against short, network, long addresses
// - short address resets to all ones
// - control bit 3 makes node coordinator
// - coordinator accepts frames without destination address
// - bit 5 sets pending flag in acks
// - bits 7:6 choose acknowledged frame versions
// - buffer control bit 7 enables buffer protection
// - slotted control bit 0 selects slotted acks
// - extended control bit 1 enables promiscuous mode
// - control bit 4 suppresses all acks
// - promiscuous mode skips address based rejection
// - promiscuous mode signals every frame end
// - host sets ack disable in promiscuous mode
// - address match raises match event everywhere
// - basic state signals start on valid header
// - frame end and fcs flag update together
// - auto ack state adds acks, safe filtering
module aarx_filter
   import aarx_pkg::*;
#(
   parameter int ADDR_W = 6
) (
   input  wire logic              mclk_i,
   input  wire logic              rst_n_i,
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic              reg_we_i,
   input  wire logic [7:0]        reg_wdata_i,
   output logic      [7:0]        reg_rdata_o,
   input  wire logic              auto_ack_receive_state_i,
   input  wire logic [4:0]        rssi_i,
   input  wire logic              phr_valid_i,
   input  wire logic              hdr_valid_i,
   input  wire logic [2:0]        frame_type_i,
   input  wire logic              ack_request_i,
   input  wire logic [1:0]        dst_mode_i,
   input  wire logic [1:0]        frame_version_i,
   input  wire logic [15:0]       dst_network_id_i,
   input  wire logic [15:0]       dst_short_i,
   input  wire logic [63:0]       dst_long_i,
   input  wire logic              frame_end_i,
   input  wire logic              fcs_ok_i,
   output logic                   rx_start_o,
   output logic                   addr_match_event_o,
   output logic                   rx_done_event_o,
   output logic                   buffer_commit_o,
   output logic                   buffer_protect_o,
   output logic                   ack_send_o,
   output logic                   ack_pending_flag_o,
   output logic                   ack_slotted_o
);
   import aarx_pkg::*;

   // refused while elaborating: the offset decode assumes six address bits
   if (ADDR_W != 6) begin
      $error("aarx_filter: register address must be 6 bits");
   end

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      aarx_state_t st;
      logic        aack;
      logic        matched;
      logic        ver_ok;
      logic        ack_req;
      logic [15:0] short_addr;
      logic [15:0] network_id;
      logic [63:0] long_addr;
      logic [7:0]  buf_ctrl;
      logic [7:0]  ext_ack;
      logic [7:0]  slotted;
      logic [7:0]  ack_filter;
      logic        fcs_valid;
      logic [7:0]  rdata;
      logic        rx_start;
      logic        match_ev;
      logic        done_ev;
      logic        commit;
      logic        ack_send;
      logic        ack_pend;
      logic        ack_slot;
   } aarx_regs_t;

   aarx_regs_t r;
   aarx_regs_t next_r;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic version_accepted(input logic [1:0] policy, input logic [1:0] ver);
      logic ok;
      ok = 1'b0;
      case (policy)
         2'b00:   ok = (ver == 2'b00);
         2'b01:   ok = (ver <= 2'b01);
         2'b10:   ok = (ver <= 2'b10);
         default: ok = 1'b1;
      endcase
      return ok;
   endfunction

   function automatic logic id_hit(input logic [15:0] own, input logic [15:0] dst);
      return (dst == own) || (dst == BCAST_ID);
   endfunction

   // ****************************************
   // combinational next state
   // ****************************************
   logic       coord;
   logic       promisc;
   logic       addr_hit;
   logic       end_ok;
   logic [7:0] status_byte;
   logic [2:0] long_idx;

   always_comb begin
      next_r   = r;
      coord    = r.ack_filter[BIT_COORD] & auto_ack_receive_state_i;
      promisc  = r.ext_ack[BIT_PROMISC] & auto_ack_receive_state_i;
      addr_hit = 1'b0;
      end_ok   = 1'b0;
      long_idx = 3'(reg_addr_i - OFF_LONG_FIRST);
      status_byte = {r.fcs_valid, 2'b00, rssi_i};

      // third level address check against own identity
      case (dst_mode_i)
         AMODE_NONE:  addr_hit = coord;
         AMODE_SHORT: addr_hit = id_hit(r.network_id, dst_network_id_i)
                                 && id_hit(r.short_addr, dst_short_i);
         AMODE_LONG:  addr_hit = id_hit(r.network_id, dst_network_id_i)
                                 && (dst_long_i == r.long_addr);
         default:     addr_hit = 1'b0;
      endcase

      next_r.rx_start = 1'b0;
      next_r.match_ev = 1'b0;
      next_r.done_ev  = 1'b0;
      next_r.commit   = 1'b0;
      next_r.ack_send = 1'b0;

      case (r.st)
         AARX_IDLE: begin
            if (phr_valid_i) begin
               next_r.st       = AARX_FRAME;
               next_r.aack     = auto_ack_receive_state_i;
               next_r.matched  = 1'b0;
               next_r.ver_ok   = 1'b0;
               next_r.ack_req  = 1'b0;
               next_r.rx_start = 1'b1;
            end
         end
         AARX_FRAME: begin
            if (hdr_valid_i) begin
               // beacons are kept by the standard second level rules
               next_r.matched  = addr_hit || (frame_type_i == FTYPE_BEACON);
               next_r.match_ev = addr_hit;
               next_r.ver_ok   = version_accepted(r.ack_filter[POS_VER_POLICY +: 2],
                                                  frame_version_i);
               next_r.ack_req  = ack_request_i && (frame_type_i != FTYPE_BEACON);
            end
            if (frame_end_i) begin
               next_r.st        = AARX_IDLE;
               next_r.fcs_valid = fcs_ok_i;
               if (!r.aack) begin
                  end_ok = 1'b1;
               end else if (r.ext_ack[BIT_PROMISC]) begin
                  end_ok = 1'b1;
               end else begin
                  // rejected frames leave the buffer untouched
                  end_ok = fcs_ok_i && r.matched;
               end
               next_r.done_ev = end_ok;
               next_r.commit  = end_ok;
               if (r.aack && fcs_ok_i && r.matched && r.ack_req && r.ver_ok
                   && !r.ack_filter[BIT_ACK_DISABLE]) begin
                  next_r.ack_send = 1'b1;
                  next_r.ack_pend = r.ack_filter[BIT_ACK_PENDING];
                  next_r.ack_slot = r.slotted[BIT_SLOTTED];
               end
            end
         end
         default: next_r.st = AARX_IDLE;
      endcase

      // promiscuous sessions still see address matches but nothing is dropped
      if (promisc && (r.st == AARX_IDLE)) begin
         next_r.matched = 1'b0;
      end

      // register writes
      if (reg_we_i) begin
         case (reg_addr_i)
            OFF_BUF_PROTECT: next_r.buf_ctrl         = reg_wdata_i;
            OFF_EXT_ACK:     next_r.ext_ack          = reg_wdata_i;
            OFF_SHORT_LO:    next_r.short_addr[7:0]  = reg_wdata_i;
            OFF_SHORT_HI:    next_r.short_addr[15:8] = reg_wdata_i;
            OFF_NETID_LO:    next_r.network_id[7:0]  = reg_wdata_i;
            OFF_NETID_HI:    next_r.network_id[15:8] = reg_wdata_i;
            OFF_SLOTTED:     next_r.slotted          = reg_wdata_i;
            OFF_ACK_FILTER:  next_r.ack_filter       = reg_wdata_i;
            default: begin
               if (reg_addr_i >= OFF_LONG_FIRST && reg_addr_i <= OFF_LONG_LAST) begin
                  next_r.long_addr[long_idx*8 +: 8] = reg_wdata_i;
               end
            end
         endcase
      end

      // register reads, one cycle latency; unmapped reads as zero
      case (reg_addr_i)
         OFF_SIGNAL_STATUS: next_r.rdata = status_byte;
         OFF_BUF_PROTECT:   next_r.rdata = r.buf_ctrl;
         OFF_EXT_ACK:       next_r.rdata = r.ext_ack;
         OFF_SHORT_LO:      next_r.rdata = r.short_addr[7:0];
         OFF_SHORT_HI:      next_r.rdata = r.short_addr[15:8];
         OFF_NETID_LO:      next_r.rdata = r.network_id[7:0];
         OFF_NETID_HI:      next_r.rdata = r.network_id[15:8];
         OFF_SLOTTED:       next_r.rdata = r.slotted;
         OFF_ACK_FILTER:    next_r.rdata = r.ack_filter;
         default: begin
            if (reg_addr_i >= OFF_LONG_FIRST && reg_addr_i <= OFF_LONG_LAST) begin
               next_r.rdata = r.long_addr[long_idx*8 +: 8];
            end else begin
               next_r.rdata = 8'h00;
            end
         end
      endcase
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         r            <= '0;
         r.st         <= AARX_IDLE;
         r.short_addr <= RST_SHORT_ADDR;
         r.network_id <= RST_NETID;
         r.long_addr  <= RST_LONG_ADDR;
         r.buf_ctrl   <= RST_BUF_CTRL;
         r.ext_ack    <= RST_EXT_ACK;
         r.slotted    <= RST_SLOTTED;
         r.ack_filter <= RST_ACK_FILTER;
      end else begin
         r <= next_r;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign reg_rdata_o        = r.rdata;
   assign rx_start_o         = r.rx_start;
   assign addr_match_event_o = r.match_ev;
   assign rx_done_event_o    = r.done_ev;
   assign buffer_commit_o    = r.commit;
   // protection only meaningful while the auto-ack filter decides what is kept
   assign buffer_protect_o   = r.buf_ctrl[BIT_BUF_PROTECT] & auto_ack_receive_state_i;
   assign ack_send_o         = r.ack_send;
   assign ack_pending_flag_o = r.ack_pend;
   assign ack_slotted_o      = r.ack_slot;

endmodule

//--- tb/aarx_filter_props.sv
// concurrent checks on the receive filter ports
`timescale 1ns/10ps
module aarx_filter_props (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic auto_ack_receive_state_i,
   input wire logic phr_valid_i,
   input wire logic hdr_valid_i,
   input wire logic frame_end_i,
   input wire logic fcs_ok_i,
   input wire logic rx_start_o,
   input wire logic addr_match_event_o,
   input wire logic rx_done_event_o,
   input wire logic buffer_commit_o,
   input wire logic buffer_protect_o,
   input wire logic ack_send_o,
   input wire logic ack_pending_flag_o,
   input wire logic ack_slotted_o
);
   // ****************************************
   // frame tracking
   // ****************************************
   logic in_frame;
   logic basic;
   // mode is latched at the header, like the design
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         in_frame <= 1'b0;
         basic    <= 1'b0;
      end else if (phr_valid_i && !in_frame) begin
         in_frame <= 1'b1;
         basic    <= !auto_ack_receive_state_i;
      end else if (frame_end_i) begin
         in_frame <= 1'b0;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_start;
      phr_valid_i && !in_frame;
   endsequence
   sequence s_end;
      frame_end_i && in_frame;
   endsequence
   a_start_on_phr: assert property (s_start |=> rx_start_o) else $error("start missing");
   a_start_cause: assert property (rx_start_o |-> $past(phr_valid_i)) else $error("stray start");
   a_match_cause: assert property (addr_match_event_o |-> $past(hdr_valid_i)) else $error("stray match");
   a_basic_end_done: assert property (s_end ##0 basic |=> rx_done_event_o) else $error("done missing");
   a_done_cause: assert property (rx_done_event_o |-> $past(frame_end_i)) else $error("stray done");
   a_commit_with_done: assert property (buffer_commit_o |-> rx_done_event_o) else $error("commit alone");
   a_ack_needs_fcs: assert property (ack_send_o |-> rx_done_event_o && $past(fcs_ok_i) && !basic)
      else $error("bad ack");
   a_protect_basic_off: assert property (!auto_ack_receive_state_i |-> !buffer_protect_o)
      else $error("protect in basic");
   a_pending_holds: assert property (!ack_send_o |=> $stable(ack_pending_flag_o) || ack_send_o)
      else $error("pending moved");
   a_slotted_holds: assert property (!ack_send_o |=> $stable(ack_slotted_o) || ack_send_o)
      else $error("slotted moved");
endmodule
bind aarx_filter aarx_filter_props u_aarx_filter_props (.mclk_i, .rst_n_i, .auto_ack_receive_state_i,
   .phr_valid_i, .hdr_valid_i, .frame_end_i, .fcs_ok_i, .rx_start_o, .addr_match_event_o, .rx_done_event_o,
   .buffer_commit_o, .buffer_protect_o, .ack_send_o, .ack_pending_flag_o, .ack_slotted_o);

//--- tb/aarx_node_model.sv
// remote node sending one frame per request
`timescale 1ns/10ps
module aarx_node_model (
   input  wire logic mclk_i,
   input  wire logic go_i,
   input  wire logic slow_i,
   input  wire logic fcs_good_i,
   output logic      phr_o,
   output logic      hdr_o,
   output logic      end_o,
   output logic      fcs_o
);
   initial begin
      {phr_o, hdr_o, end_o, fcs_o} = 4'h0;
      forever begin
         @(posedge mclk_i iff go_i);
         #1 phr_o = 1'b1;
         @(posedge mclk_i);
         #1 phr_o = 1'b0;
         @(posedge mclk_i);
         #1 hdr_o = 1'b1;
         @(posedge mclk_i);
         #1 hdr_o = 1'b0;
         if (slow_i) repeat (3) @(posedge mclk_i);
         @(posedge mclk_i);
         #1 end_o = 1'b1;
         fcs_o = fcs_good_i;
         @(posedge mclk_i);
         #1 end_o = 1'b0;
         // inverted after the frame end, never a stale value
         fcs_o = ~fcs_o;
      end
   end
endmodule

//--- tb/test_auto_ack_rx_filter_config.sv
// self-checking bench of the receive filter
`timescale 1ns/10ps
module test_auto_ack_rx_filter_config;
   import aarx_pkg::*;
   logic        mclk_i = 1'b0, rst_n_i = 1'b0, reg_we_i = 1'b0, auto_ack_receive_state_i = 1'b0;
   logic [5:0]  reg_addr_i = 6'h00;
   logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o;
   logic [1:0]  dst_mode_i = 2'h2, frame_version_i = 2'h0;
   logic [15:0] dst_short_i = 16'h0000;
   logic        go = 1'b0, slow = 1'b0, good = 1'b0, s_st, s_mt, s_dn, s_ak, s_cm;
   logic        phr_valid_i, hdr_valid_i, frame_end_i, fcs_ok_i, rx_start_o, addr_match_event_o;
   logic        rx_done_event_o, buffer_commit_o, buffer_protect_o, ack_send_o, ack_pending_flag_o, ack_slotted_o;
   int          bad_count = 0, num_checks = 0, cyc = 0;
   always #4 mclk_i = ~mclk_i;
   // fixed header fields; the network id matches the programmed one
   aarx_filter u_aarx_filter (.mclk_i, .rst_n_i, .reg_addr_i, .reg_we_i, .reg_wdata_i, .reg_rdata_o,
      .auto_ack_receive_state_i, .rssi_i(5'h15), .phr_valid_i, .hdr_valid_i, .frame_type_i(3'h1),
      .ack_request_i(1'b1), .dst_mode_i, .frame_version_i, .dst_network_id_i(16'h00ab), .dst_short_i,
      .dst_long_i(64'h0), .frame_end_i, .fcs_ok_i, .rx_start_o, .addr_match_event_o, .rx_done_event_o,
      .buffer_commit_o, .buffer_protect_o, .ack_send_o, .ack_pending_flag_o, .ack_slotted_o);
   aarx_node_model u_aarx_node_model (.mclk_i, .go_i(go), .slow_i(slow), .fcs_good_i(good),
      .phr_o(phr_valid_i), .hdr_o(hdr_valid_i), .end_o(frame_end_i), .fcs_o(fcs_ok_i));
   // ****************************************
   // tasks
   // ****************************************
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      #1 reg_addr_i = a;
      reg_wdata_i = d;
      reg_we_i = 1'b1;
      @(posedge mclk_i);
      #1 reg_we_i = 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      @(posedge mclk_i);
      #1 reg_addr_i = a;
      @(posedge mclk_i);
      #1 check($sformatf("reg %h", a), exp, reg_rdata_o);
   endtask
   task automatic frame(input logic aa, input logic [1:0] m, input logic [1:0] v, input logic [15:0] d,
                        input logic g, input logic exp_dn, input logic exp_ak);
      @(posedge mclk_i);
      #1 auto_ack_receive_state_i = aa;
      dst_mode_i = m;
      frame_version_i = v;
      dst_short_i = d;
      good = g;
      {s_st, s_mt, s_dn, s_ak, s_cm} = 5'h00;
      go = 1'b1;
      @(posedge mclk_i);
      #1 go = 1'b0;
      repeat (12) @(posedge mclk_i);
      #1 check("start", 8'h01, s_st);
      check("done", exp_dn, s_dn);
      check("ack", exp_ak, s_ak);
      check("commit", exp_dn, s_cm);
   endtask
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (rx_start_o) s_st <= 1'b1;
      if (addr_match_event_o) s_mt <= 1'b1;
      if (rx_done_event_o) s_dn <= 1'b1;
      if (ack_send_o) s_ak <= 1'b1;
      if (buffer_commit_o) s_cm <= 1'b1;
      if (cyc > 3000) begin
         bad_count++;
         complete_run();
      end
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      int c;
      int v;
      repeat (3) @(posedge mclk_i);
      #1 rst_n_i = 1'b1;
      rd(OFF_SHORT_LO, 8'hff);
      rd(OFF_SHORT_HI, 8'hff);
      rd(OFF_ACK_FILTER, 8'h40);
      wr(OFF_SHORT_LO, 8'h34);
      wr(OFF_SHORT_HI, 8'h12);
      wr(OFF_NETID_LO, 8'hab);
      rd(OFF_SHORT_HI, 8'h12);
      wr(OFF_LONG_LAST, 8'h5a);
      rd(OFF_LONG_LAST, 8'h5a);
      wr(6'h3f, 8'h77);
      rd(6'h3f, 8'h00);
      wr(OFF_SIGNAL_STATUS, 8'h60);
      rd(OFF_SIGNAL_STATUS, 8'h15);
      frame(1'b0, AMODE_SHORT, 2'h0, 16'h9999, 1'b0, 1'b1, 1'b0);
      check("match", 8'h00, s_mt);
      rd(OFF_SIGNAL_STATUS, 8'h15);
      frame(1'b1, AMODE_SHORT, 2'h0, 16'h1234, 1'b1, 1'b1, 1'b1);
      check("match", 8'h01, s_mt);
      check("pending", 8'h00, ack_pending_flag_o);
      rd(OFF_SIGNAL_STATUS, 8'h95);
      wr(OFF_ACK_FILTER, 8'h60);
      wr(OFF_SLOTTED, 8'h01);
      frame(1'b1, AMODE_SHORT, 2'h0, 16'h1234, 1'b1, 1'b1, 1'b1);
      check("pending", 8'h01, ack_pending_flag_o);
      check("slotted", 8'h01, ack_slotted_o);
      for (c = 0; c < 4; c++) begin
         for (v = 0; v < 4; v++) begin
            wr(OFF_ACK_FILTER, {c[1:0], 6'h00});
            frame(1'b1, AMODE_SHORT, v[1:0], 16'h1234, 1'b1, 1'b1, c == 3 || v <= c);
         end
      end
      wr(OFF_ACK_FILTER, 8'h50);
      frame(1'b1, AMODE_SHORT, 2'h0, 16'h1234, 1'b1, 1'b1, 1'b0);
      wr(OFF_ACK_FILTER, 8'h40);
      frame(1'b1, AMODE_NONE, 2'h0, 16'h1234, 1'b1, 1'b0, 1'b0);
      // long destination is all zeros; own long address still holds 0x5a in its top byte
      frame(1'b1, AMODE_LONG, 2'h0, 16'h1234, 1'b1, 1'b0, 1'b0);
      wr(OFF_LONG_LAST, 8'h00);
      frame(1'b1, AMODE_LONG, 2'h0, 16'h1234, 1'b1, 1'b1, 1'b1);
      check("match", 8'h01, s_mt);
      wr(OFF_ACK_FILTER, 8'h48);
      frame(1'b1, AMODE_NONE, 2'h0, 16'h1234, 1'b1, 1'b1, 1'b1);
      frame(1'b0, AMODE_NONE, 2'h0, 16'h1234, 1'b1, 1'b1, 1'b0);
      wr(OFF_BUF_PROTECT, 8'h80);
      auto_ack_receive_state_i = 1'b1;
      #1 check("protect", 8'h01, buffer_protect_o);
      for (c = 32; c < 44; c++) wr(c[5:0], 8'h00);
      wr(OFF_EXT_ACK, 8'h02);
      wr(OFF_ACK_FILTER, 8'h50);
      slow = 1'b1;
      frame(1'b1, AMODE_SHORT, 2'h0, 16'h9999, 1'b0, 1'b1, 1'b0);
      rd(OFF_SIGNAL_STATUS, 8'h15);
      complete_run();
   end
endmodule
